// ==== design/duty_divider.v ====
`timescale 1ns/1ps
`include "duty_divider_map.vh"

// Functional notes
// RULE1 - Even stage: low count equals high count.
// RULE2 - Odd stage: low count one above high.
// RULE3 - Single bypass must be the second stage.
// RULE4 - Single even ratio belongs in second stage.
// RULE5 - Raw duty from prescaler or last stage.
// RULE6 - Raw external input passes duty through.
// RULE7 - Correction on, balanced input gives half.
// RULE8 - Corrected odd prescaler keeps input fraction.
// RULE9 - Residual skew only with odd chains.
// RULE10 - Fields hold cycles minus one.
// RULE11 - Correction on after reset until disabled.

module duty_divider
(
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        vco_in,
   input  wire        ext_clk_in,
   output reg         clk_out
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   reg        vco_meta_reg;
   reg        vco_sync_reg;
   reg        ext_meta_reg;
   reg        ext_sync_reg;

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         vco_meta_reg <= 1'b0;
         vco_sync_reg <= 1'b0;
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
      end
      else
      begin
         vco_meta_reg <= vco_in;
         vco_sync_reg <= vco_meta_reg;
         ext_meta_reg <= ext_clk_in;
         ext_sync_reg <= ext_meta_reg;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg  [31:0] ctrl_reg;
   reg  [31:0] stage1_reg;
   reg  [31:0] stage2_reg;
   reg  [7:0]  addr_reg;
   reg         wr_pend_reg;
   reg  [31:0] rdata_next;
   wire [31:0] status_word;
   wire        take;

   assign take = hsel & htrans[1] & hready;

   always @*
   begin
      if (haddr[7:0] == `CTRL_OFFSET)
      begin
         rdata_next = ctrl_reg;
      end
      else if (haddr[7:0] == `STAGE1_OFFSET)
      begin
         rdata_next = stage1_reg;
      end
      else if (haddr[7:0] == `STAGE2_OFFSET)
      begin
         rdata_next = stage2_reg;
      end
      else if (haddr[7:0] == `STATUS_OFFSET)
      begin
         rdata_next = status_word;
      end
      else
      begin
         rdata_next = 32'h0000_0000;
      end
   end

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_reg    <= `CTRL_RESET; // [RULE11]
         stage1_reg  <= `STAGE_RESET;
         stage2_reg  <= `STAGE_RESET;
         addr_reg    <= 8'h00;
         wr_pend_reg <= 1'b0;
         hrdata      <= 32'h0000_0000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (wr_pend_reg)
         begin
            // Only written fields are kept; other bits read as zero.
            if (addr_reg == `CTRL_OFFSET)
            begin
               ctrl_reg <= hwdata & 32'h0000_0073; // [RULE11]
            end
            else if (addr_reg == `STAGE1_OFFSET)
            begin
               stage1_reg <= hwdata & 32'h0000_01FF; // [RULE10]
            end
            else if (addr_reg == `STAGE2_OFFSET)
            begin
               stage2_reg <= hwdata & 32'h0000_01FF; // [RULE10]
            end
         end
         if (take)
         begin
            addr_reg    <= haddr[7:0];
            wr_pend_reg <= hwrite;
            if (!hwrite)
            begin
               hrdata <= rdata_next;
            end
         end
         else
         begin
            wr_pend_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Prescaler and cascaded stages
   // ------------------------------------------------------------
   wire [2:0] pre_ratio;
   wire       pre_used;
   wire [3:0] pre_high;
   wire [3:0] pre_low;
   wire       pre_out;
   wire       corr_en;
   wire       src_level;
   wire [2:0] chain;
   wire [3:0] stg_high [0:1];
   wire [3:0] stg_low  [0:1];
   wire [1:0] stg_byp;

   assign pre_ratio = ctrl_reg[`CTRL_PRE_MSB:`CTRL_PRE_LSB];
   // Ratios below two put the prescaler in bypass, a registered copy one cycle late.
   assign pre_used  = pre_ratio > 3'h1;
   // Raw prescaler is high for the lower half: 1 of 3, 2 of 5.
   assign pre_high  = {2'b00, pre_ratio[2:1]} - 4'h1; // [RULE5]
   assign pre_low   = {1'b0, pre_ratio} - {2'b00, pre_ratio[2:1]} - 4'h1;
   assign corr_en   = ~ctrl_reg[`CTRL_CORR_OFF_BIT]; // [RULE11]

   assign stg_high[0] = stage1_reg[`STG_HIGH_MSB:`STG_HIGH_LSB];
   assign stg_low[0]  = stage1_reg[`STG_LOW_MSB:`STG_LOW_LSB];
   assign stg_high[1] = stage2_reg[`STG_HIGH_MSB:`STG_HIGH_LSB];
   assign stg_low[1]  = stage2_reg[`STG_LOW_MSB:`STG_LOW_LSB];
   assign stg_byp     = {stage2_reg[`STG_BYPASS_BIT],
                         stage1_reg[`STG_BYPASS_BIT]};

   divider_stage prescaler
   (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_level  (vco_sync_reg),
      .high_cnt  (pre_high),
      .low_cnt   (pre_low),
      .bypass    (~pre_used),
      .corr_en   (corr_en), // [RULE8]
      .out_level (pre_out)
   );

   // External input goes straight in, keeping its duty. [RULE6]
   assign src_level = ctrl_reg[`CTRL_SRC_BIT] ? ext_sync_reg : pre_out;
   assign chain[0]  = src_level;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : stage
         divider_stage cascade
         (
            .ref_clk   (ref_clk),
            .rst       (rst),
            .in_level  (chain[g]),
            .high_cnt  (stg_high[g]),
            .low_cnt   (stg_low[g]),
            .bypass    (stg_byp[g]),
            .corr_en   (corr_en), // [RULE7] [RULE9]
            .out_level (chain[g+1])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Output and configuration checks
   // ------------------------------------------------------------
   reg  [1:0] bal_ok;
   reg        byp_bad;
   reg        even_bad;
   wire [1:0] stg_odd;

   assign stg_odd = {stg_high[1][0] ^ stg_low[1][0],
                     stg_high[0][0] ^ stg_low[0][0]};

   integer i;
   always @*
   begin
      for (i = 0; i < 2; i = i + 1)
      begin
         if (stg_byp[i])
         begin
            bal_ok[i] = 1'b1;
         end
         else if (stg_odd[i])
         begin
            bal_ok[i] = stg_low[i] == stg_high[i] + 4'h1; // [RULE2]
         end
         else
         begin
            bal_ok[i] = stg_low[i] == stg_high[i]; // [RULE1]
         end
      end
      byp_bad  = stg_byp[0] & ~stg_byp[1]; // [RULE3]
      even_bad = ~stg_byp[0] & ~stg_byp[1] &
                 ~stg_odd[0] & stg_odd[1]; // [RULE4]
   end

   // Correction leans on the configuration; status only reports misuse.
   assign status_word = {25'h000_0000, even_bad, byp_bad, ~(&bal_ok),
                         corr_en, chain[2], chain[1], clk_out};

   // Retimed so the pin comes from a flip-flop; adds one cycle of delay.
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         clk_out <= 1'b0;
      end
      else
      begin
         clk_out <= chain[2]; // [RULE5] [RULE6]
      end
   end

endmodule // duty_divider

// ==== common/duty_divider_map.vh ====
`ifndef DUTY_DIVIDER_MAP_VH
`define DUTY_DIVIDER_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define CTRL_OFFSET        8'h00
`define STAGE1_OFFSET      8'h04
`define STAGE2_OFFSET      8'h08
`define STATUS_OFFSET      8'h0C

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define CTRL_SRC_BIT       0
`define CTRL_CORR_OFF_BIT  1
`define CTRL_PRE_LSB       4
`define CTRL_PRE_MSB       6

// ------------------------------------------------------------
// Stage register fields
// ------------------------------------------------------------
`define STG_HIGH_LSB       0
`define STG_HIGH_MSB       3
`define STG_LOW_LSB        4
`define STG_LOW_MSB        7
`define STG_BYPASS_BIT     8

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define STAT_OUT_BIT       0
`define STAT_S1_BIT        1
`define STAT_S2_BIT        2
`define STAT_CORR_BIT      3
`define STAT_BAL_BIT       4
`define STAT_BYP_BIT       5
`define STAT_EVEN_BIT      6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CTRL_RESET         32'h0000_0020
`define STAGE_RESET        32'h0000_0100

`endif

// ==== design/divider_stage.v ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// One divider stage counting rising edges of a sampled input.
// ------------------------------------------------------------
module divider_stage
(
   input  wire       ref_clk,
   input  wire       rst,
   input  wire       in_level,
   input  wire [3:0] high_cnt,
   input  wire [3:0] low_cnt,
   input  wire       bypass,
   input  wire       corr_en,
   output reg        out_level
);

   reg        in_prev_reg;
   reg        phase_reg;
   reg        hold_reg;
   reg  [3:0] cnt_reg;
   wire       rise;
   wire       fall;
   wire       odd_total;
   wire [3:0] limit;

   assign rise      = in_level & ~in_prev_reg;
   assign fall      = ~in_level & in_prev_reg;
   // Total is N + M + 2, so its parity is that of N + M.
   assign odd_total = high_cnt[0] ^ low_cnt[0];
   assign limit     = phase_reg ? high_cnt : low_cnt;

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         in_prev_reg <= 1'b0;
         phase_reg   <= 1'b0;
         hold_reg    <= 1'b0;
         cnt_reg     <= 4'h0;
         out_level   <= 1'b0;
      end
      else
      begin
         in_prev_reg <= in_level;
         if (bypass)
         begin
            out_level <= in_level;
            phase_reg <= 1'b0;
            hold_reg  <= 1'b0;
            cnt_reg   <= 4'h0;
         end
         else
         begin
            if (rise)
            begin
               // A limit lowered below the count ends the phase at the next input rise.
               if (cnt_reg >= limit)
               begin
                  cnt_reg   <= 4'h0;
                  phase_reg <= ~phase_reg;
                  if (phase_reg && corr_en && odd_total)
                  begin
                     // Keep high until the input falls, half an input cycle for a balanced input. [RULE7]
                     hold_reg <= 1'b1; // [RULE8] [RULE9]
                  end
                  else
                  begin
                     out_level <= ~phase_reg; // [RULE10] [RULE5] [RULE6]
                  end
               end
               else
               begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            if (hold_reg && fall)
            begin
               hold_reg  <= 1'b0;
               out_level <= 1'b0;
            end
         end
      end
   end

endmodule // divider_stage

// ==== dv/clk_source.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Upstream clock source driving both input pins.
// ------------------------------------------------------------
module clk_source
(
   input  wire logic       ref_clk,
   input  wire logic [7:0] hi_len,
   input  wire logic [7:0] lo_len,
   output wire logic       vco_in,
   output wire logic       ext_clk_in
);
   logic [7:0] cnt_reg = 8'h00;
   logic       lvl_reg = 1'b0;
   // Falling-edge updates keep the pins half a cycle away from the block's sampling edge.
   always @(negedge ref_clk)
   begin
      if (cnt_reg + 8'h01 >= (lvl_reg ? hi_len : lo_len))
      begin
         cnt_reg <= 8'h00;
         lvl_reg <= ~lvl_reg;
      end
      else
         cnt_reg <= cnt_reg + 8'h01;
   end
   assign vco_in     = lvl_reg;
   assign ext_clk_in = lvl_reg;
endmodule // clk_source

// ==== dv/duty_divider_monitor.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checks of the duty divider.
// ------------------------------------------------------------
module duty_divider_monitor
(
   input wire        ref_clk,
   input wire        rst,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   input wire        clk_out
);
   wire rd_go = hsel & htrans[1] & hready & ~hwrite;
   wire wr_go = hsel & htrans[1] & hready & hwrite;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence wr_ctrl;
      wr_go && haddr[7:0] == 8'h00;
   endsequence
   // A read right behind a write sees the old value, so two idle cycles are kept.
   sequence wr_rd(logic [7:0] a);
      wr_ctrl ##3 (rd_go && haddr[7:0] == a);
   endsequence
   a_ready_high: assert property (hreadyout) else $error("hreadyout low");
   a_resp_okay: assert property (!hresp) else $error("hresp not okay");
   a_corr_flag: assert property (wr_rd(8'h0C) |=>
      hrdata[3] == !$past(hwdata[1], 3))
      else $error("correction flag wrong");
   a_ctrl_back: assert property (wr_rd(8'h00) |=>
      hrdata[6:4] == $past(hwdata[6:4], 3)) else $error("ctrl readback");
   a_status_out: assert property (rd_go && haddr[7:0] == 8'h0C |=>
      hrdata[0] == $past(clk_out)) else $error("status out bit");
   a_unmapped_zero: assert property (rd_go && haddr[7:2] > 6'h03 |=>
      hrdata == 32'h0) else $error("unmapped read not zero");
   a_hrdata_hold: assert property (!rd_go |=> $stable(hrdata))
      else $error("hrdata moved");
   a_release_low: assert property ($fell(rst) |-> !clk_out [*3])
      else $error("clk_out early");
endmodule // duty_divider_monitor

// ==== dv/duty_divider_tb.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench of the duty divider.
// ------------------------------------------------------------
module duty_divider_tb;
   logic        ref_clk, rst, hsel, hwrite;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, rv, r, hi, pe;
   logic [7:0]  hi_len, lo_len;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, vco_in, ext_clk_in, clk_out;
   int          bad_count, compares, seed, n;
   logic [31:0] st1 [4] = '{32'h100, 32'h11, 32'h2, 32'h1};
   logic [31:0] st2 [4] = '{32'h10, 32'h10, 32'h100, 32'h100};
   int          sb [4] = '{5, 6, 4, 4};
   duty_divider DUT (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .vco_in(vco_in),
      .ext_clk_in(ext_clk_in), .clk_out(clk_out));
   clk_source src (.ref_clk(ref_clk), .hi_len(hi_len), .lo_len(lo_len),
      .vco_in(vco_in), .ext_clk_in(ext_clk_in));
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   function logic [31:0] span(input logic [31:0] c, input logic [31:0] t);
      return (c + 32'h1) * t;
   endfunction
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      compares++;
      if (seen !== e)
      begin
         bad_count++;
         $display("MISMATCH %s exp %h seen %h", nm, e, seen);
      end
   endtask
   task give_verdict;
      $display("mismatches %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Reads start one cycle late so a preceding write has landed.
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      if (!w)
         @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task till(input logic v);
      n = 0;
      while (clk_out !== v && n < 3000)
      begin
         @(negedge ref_clk);
         n++;
      end
   endtask
   task meas;
      till(1'b0);
      till(1'b1);
      till(1'b0);
      hi = n;
      till(1'b1);
      pe = hi + n;
   endtask
   // The first periods after a change are dropped: counters carry over from the old setting.
   task run(input logic [31:0] c, s1, s2, input logic [7:0] h, l,
            input logic [31:0] eh, ep);
      hi_len = h;
      lo_len = l;
      bus(1'b1, 32'h0, c);
      bus(1'b1, 32'h4, s1);
      bus(1'b1, 32'h8, s2);
      repeat (3) meas;
      chk("high", hi, eh);
      chk("period", pe, ep);
   endtask
   initial
   begin
      #2000000;
      bad_count++;
      give_verdict;
   end
   initial
   begin
      seed = 32'hD318;
      bad_count = 0;
      compares = 0;
      rst = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      {hi_len, lo_len} = {8'h2, 8'h2};
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      bus(1'b0, 32'h0, 32'h0);
      chk("ctrl", rv, 32'h20);
      bus(1'b0, 32'h4, 32'h0);
      chk("stage1", rv, 32'h100);
      bus(1'b1, 32'h10, 32'hFFFFFFFF);
      bus(1'b0, 32'h10, 32'h0);
      chk("unmapped", rv, 32'h0);
      run(32'h32, 32'h100, 32'h100, 2, 2, 4, 12);
      run(32'h52, 32'h100, 32'h100, 2, 2, 8, 20);
      run(32'h22, 32'h100, 32'h100, 2, 2, 4, 8);
      run(32'h32, 32'h11, 32'h100, 2, 2, 24, 48);
      run(32'h30, 32'h100, 32'h100, 2, 2, 6, 12);
      run(32'h30, 32'h100, 32'h100, 2, 4, 8, 18);
      run(32'h3, 32'h100, 32'h100, 2, 4, 2, 6);
      run(32'h3, 32'h0, 32'h10, 2, 2, 8, 24);
      run(32'h1, 32'h10, 32'h100, 2, 2, 6, 12);
      run(32'h1, 32'h10, 32'h100, 2, 4, 8, 18);
      run(32'h1, 32'h10, 32'h0, 2, 4, 18, 36);
      repeat (3)
      begin
         r = $random(seed);
         run(32'h3, r & 32'h33, 32'h100, 2, 2, span(r & 32'h3, 4),
             span((r & 32'h3) + ((r >> 4) & 32'h3) + 32'h1, 4));
      end
      foreach (st1[i])
      begin
         bus(1'b1, 32'h4, st1[i]);
         bus(1'b1, 32'h8, st2[i]);
         bus(1'b0, 32'hC, 32'h0);
         chk("flag", rv[sb[i]], 1'b1);
      end
      bus(1'b1, 32'h0, 32'h22);
      bus(1'b0, 32'hC, 32'h0);
      chk("corr off", rv[3], 1'b0);
      bus(1'b1, 32'h0, 32'h51);
      bus(1'b0, 32'h0, 32'h0);
      chk("ctrl", rv, 32'h51);
      bus(1'b1, 32'h0, 32'h22);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      bus(1'b0, 32'hC, 32'h0);
      chk("corr reset", rv[3], 1'b1);
      give_verdict;
   end
endmodule // duty_divider_tb
bind duty_divider duty_divider_monitor mon (.ref_clk(ref_clk), .rst(rst),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .clk_out(clk_out));
